// ==== tcc_regs.svh ====
// Constants of the timer/counter with capture/compare channels
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// Channel count and counter word size
`define TCC_NUM_CHAN        6
`define TCC_CHAN_IDX_W      3
`define TCC_WORD_W          32

// Width select encodings
`define TCC_WIDTH_16        2'h0
`define TCC_WIDTH_08        2'h1
`define TCC_WIDTH_24        2'h2
`define TCC_WIDTH_32        2'h3

// Counter masks for each width
`define TCC_MASK_16         32'h0000ffff
`define TCC_MASK_08         32'h000000ff
`define TCC_MASK_24         32'h00ffffff
`define TCC_MASK_32         32'hffffffff

// Divider exponent field and the point where the slow source takes over
`define TCC_DIV_EXP_W       4
`define TCC_SLOW_SRC_EXP    4'h4
`define TCC_PRESC_W         16

// Reset values
`define TCC_RST_COUNT       32'h00000000
`define TCC_RST_CHAN        32'h00000000
`define TCC_RST_PRESC       16'h0000
`define TCC_RST_ARMED       6'h3f

`endif

// ==== tcc_pkg.sv ====
// Types shared by the timer/counter modules
package tcc_pkg;

    // Operating mode of the counter
    typedef enum logic {TCC_MODE_TIMER, TCC_MODE_COUNTER} tcc_mode_t;

    // Run state of the counter
    typedef enum logic {TCC_HALTED, TCC_RUNNING} tcc_run_t;

    // One counter or channel word
    typedef logic [31:0] tcc_word_t;

    // One flag per channel
    typedef logic [5:0] tcc_chan_vec_t;

endpackage

// ==== tcc_chan_if.sv ====
// Carrier between the counter core and its channel value bank
`timescale 1ns/1ps
interface tcc_chan_if;
    import tcc_pkg::*;

    tcc_chan_vec_t cap_en;       // Capture strobe per channel
    tcc_word_t     cap_data;     // Value to capture
    tcc_chan_vec_t wr_en;        // Software write strobe per channel
    tcc_word_t     wr_data;      // Software write data
    logic [2:0]    rd_sel;       // Read select
    tcc_word_t     rd_data;      // Registered read data
    tcc_word_t     value [6];    // All channel values for comparison
    tcc_chan_vec_t armed;        // Single-match arm per channel
    tcc_chan_vec_t disarm;       // Disarm strobe per channel

    modport core (output cap_en, cap_data, wr_en, wr_data, rd_sel, disarm,
                  input  rd_data, value, armed);
    modport bank (input  cap_en, cap_data, wr_en, wr_data, rd_sel, disarm,
                  output rd_data, value, armed);
endinterface

// ==== tcc_chan_bank.sv ====
// Channel value registers with single-match arming and registered read
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_chan_bank
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // Channel carrier
    tcc_chan_if.bank  chan
);

    tcc_word_t     value_r [`TCC_NUM_CHAN];
    tcc_chan_vec_t armed_r;

    // Per-channel value and arm state
    genvar g;
    generate
        for (g = 0; g < `TCC_NUM_CHAN; g++)
        begin : g_chan
            // Capture beats a software write in the same cycle
            always_ff @(posedge i_ref_clk)
            begin
                if (!i_rst_n)
                    value_r[g] <= `TCC_RST_CHAN;
                else if (chan.cap_en[g])
                    value_r[g] <= chan.cap_data;
                else if (chan.wr_en[g])
                    value_r[g] <= chan.wr_data;
            end

            // Arm on write, disarm after a single match; write wins
            always_ff @(posedge i_ref_clk)
            begin
                if (!i_rst_n)
                    armed_r[g] <= 1'b1;
                else if (chan.wr_en[g])
                    armed_r[g] <= 1'b1;
                else if (chan.disarm[g])
                    armed_r[g] <= 1'b0;
            end

            assign chan.value[g] = value_r[g];
        end
    endgenerate

    // Registered read port; out-of-range select reads zero
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            chan.rd_data <= `TCC_RST_CHAN;
        else if (chan.rd_sel < 3'(`TCC_NUM_CHAN))
            chan.rd_data <= value_r[chan.rd_sel];
        else
            chan.rd_data <= `TCC_RST_CHAN;
    end

    assign chan.armed = armed_r;

endmodule // tcc_chan_bank

// ==== tcc_timer.sv ====
// Timer/counter core with six capture/compare channels
//
// Summary of operation
// - Start task begins counting, halt task stops it, in both modes.
// - Resuming after halt continues from the held counter value.
// - Timer mode increments on each tick of 16 MHz over two to the exponent.
// - Four-bit divider exponent selects power-of-two division.
// - At or below 1 MHz the ticks come from the 1 MHz clock.
// - Counter mode increments on increment task, ignoring the divider.
// - Timer mode ignores the increment task.
// - Width select sets the counter maximum value.
// - Increment past maximum wraps to zero and keeps counting.
// - Zero task sets the counter to zero.
// - One snapshot task and one match event per channel.
// - Snapshot task copies the counter into the channel value register.
// - Match event only when an increment makes counter equal the channel.
// - Comparison uses only bits inside the configured width.
// - Single-match raises the event only on first match after a write or reset.
// - Zero, increment and halt tasks act within one fast clock cycle.
// - Start and halt together: halt wins.
// - Snapshot and zero together: zero wins, channel receives zero.
// - Six channels, zero through five, each with snapshot and value.
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tcc_timer
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Base clock tick enables, one cycle each
    input  wire logic        i_periph_clk_sixteen_tick,
    input  wire logic        i_periph_clk_one_tick,
    // Tasks, one-cycle pulses
    input  wire logic        i_task_start,
    input  wire logic        i_task_halt,
    input  wire logic        i_task_increment,
    input  wire logic        i_task_zero,
    input  wire logic [5:0]  i_task_snapshot,
    // Configuration
    input  wire logic        i_mode_counter,
    input  wire logic [1:0]  i_width_select,
    input  wire logic [3:0]  i_divider_exp,
    input  wire logic [5:0]  i_single_match_enable,
    // Channel value write and read
    input  wire logic [5:0]  i_chan_wr_en,
    input  wire logic [31:0] i_chan_wr_data,
    input  wire logic [2:0]  i_chan_rd_sel,
    // Match flag clear, one-cycle pulses
    input  wire logic [5:0]  i_match_flag_clr,
    // Status
    output logic             o_running,
    output logic             o_slow_source,
    output logic [31:0]      o_count_value,
    output logic [31:0]      o_chan_rd_data,
    // Events and flags
    output logic [5:0]       o_match_event,
    output logic [5:0]       o_match_flag
);

    // Internal state
    tcc_run_t      run_r;
    tcc_run_t      run_nxt;
    tcc_word_t     count_r;
    tcc_word_t     count_nxt;
    tcc_word_t     count_inc;
    tcc_word_t     width_mask;
    logic [`TCC_PRESC_W-1:0] presc_r;
    logic [`TCC_PRESC_W-1:0] presc_mask;
    logic [3:0]    presc_shift;
    logic          slow_src;
    logic          src_tick;
    logic          timer_tick;
    logic          inc_req;
    logic          do_inc;
    tcc_mode_t     mode;
    tcc_chan_vec_t match_hit;
    tcc_chan_vec_t match_fire;
    tcc_chan_vec_t match_evt_r;
    tcc_chan_vec_t match_flag_r;
    logic          slow_src_r;

    // Channel bank carrier
    tcc_chan_if chan ();

    assign mode = i_mode_counter ? TCC_MODE_COUNTER : TCC_MODE_TIMER;

    // Run state: halt beats start in the same cycle
    always_comb
    begin
        run_nxt = run_r;
        if (i_task_halt)
            run_nxt = TCC_HALTED;
        else if (i_task_start)
            run_nxt = TCC_RUNNING;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            run_r <= TCC_HALTED;
        else
            run_r <= run_nxt;
    end

    // Maximum counter value from the width select
    always_comb
    begin
        width_mask = `TCC_MASK_16;
        unique case (i_width_select)
            `TCC_WIDTH_16: width_mask = `TCC_MASK_16;
            `TCC_WIDTH_08: width_mask = `TCC_MASK_08;
            `TCC_WIDTH_24: width_mask = `TCC_MASK_24;
            `TCC_WIDTH_32: width_mask = `TCC_MASK_32;
        endcase
    end

    // Source choice: exponents of four and up give 1 MHz or less
    always_comb
    begin
        slow_src    = (i_divider_exp >= `TCC_SLOW_SRC_EXP);
        presc_shift = slow_src ? (i_divider_exp - `TCC_SLOW_SRC_EXP)
                               : i_divider_exp;
        presc_mask  = ~(`TCC_PRESC_W'(16'hffff) << presc_shift);
        src_tick    = slow_src ? i_periph_clk_one_tick
                               : i_periph_clk_sixteen_tick;
    end

    // Timer tick when all divided bits of the prescaler are ones
    assign timer_tick = src_tick && ((presc_r & presc_mask) == presc_mask);

    // Prescaler runs only while timing; zero task restarts it for accuracy
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            presc_r <= `TCC_RST_PRESC;
        else if (i_task_zero)
            presc_r <= `TCC_RST_PRESC;
        else if ((run_r == TCC_RUNNING) && (mode == TCC_MODE_TIMER) && src_tick)
            presc_r <= presc_r + `TCC_PRESC_W'(16'h0001);
    end

    // Increment request depends on mode
    always_comb
    begin
        inc_req = 1'b0;
        unique case (mode)
            TCC_MODE_TIMER:   inc_req = timer_tick;
            TCC_MODE_COUNTER: inc_req = i_task_increment;
        endcase
    end

    // An increment happens only while running and never with a zero task
    assign do_inc = (run_r == TCC_RUNNING) && inc_req && !i_task_zero;

    // Next count wraps at the configured width
    assign count_inc = (count_r + 32'h00000001) & width_mask;

    always_comb
    begin
        count_nxt = count_r;
        if (i_task_zero)
            count_nxt = `TCC_RST_COUNT;
        else if (do_inc)
            count_nxt = count_inc;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            count_r <= `TCC_RST_COUNT;
        else
            count_r <= count_nxt;
    end

    // Snapshot, write and read traffic into the channel bank
    always_comb
    begin
        chan.cap_en   = i_task_snapshot;
        chan.cap_data = i_task_zero ? `TCC_RST_COUNT : count_r;
        chan.wr_en    = i_chan_wr_en;
        chan.wr_data  = i_chan_wr_data;
        chan.rd_sel   = i_chan_rd_sel;
        chan.disarm   = match_fire & i_single_match_enable;
    end

    // Compare per channel on the incremented value, masked to the width
    genvar g;
    generate
        for (g = 0; g < `TCC_NUM_CHAN; g++)
        begin : g_cmp
            assign match_hit[g] = do_inc &&
                ((count_inc & width_mask) == (chan.value[g] & width_mask));
            assign match_fire[g] = match_hit[g] &&
                (!i_single_match_enable[g] || chan.armed[g]);
        end
    endgenerate

    // Match events, one cycle each
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            match_evt_r <= 6'h00;
        else
            match_evt_r <= match_fire;
    end

    // Sticky match flags; a new match beats a clear in the same cycle
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            match_flag_r <= 6'h00;
        else
            match_flag_r <= (match_flag_r & ~i_match_flag_clr) | match_fire;
    end

    // Clock source status
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            slow_src_r <= 1'b0;
        else
            slow_src_r <= slow_src;
    end

    // Six channel value registers
    tcc_chan_bank u_bank (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .chan      (chan.bank)
    );

    // Outputs straight from flip-flops
    assign o_running      = (run_r == TCC_RUNNING);
    assign o_slow_source  = slow_src_r;
    assign o_count_value  = count_r;
    assign o_chan_rd_data = chan.rd_data;
    assign o_match_event  = match_evt_r;
    assign o_match_flag   = match_flag_r;

endmodule // tcc_timer

// ==== tcc_tick_gen.sv ====
// Base tick source standing in for the fast and slow peripheral clocks
`timescale 1ns/1ps
module tcc_tick_gen
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    // Base ticks, one cycle each
    output logic      o_tick_sixteen,
    output logic      o_tick_one
);
    logic [1:0] ph_r;
    logic [3:0] sub_r;

    // Fast tick every third cycle
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n || ph_r == 2'h2)
            ph_r <= 2'h0;
        else
            ph_r <= ph_r + 2'h1;
    end

    // Slow tick on every sixteenth fast tick
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            sub_r <= 4'h0;
        else if (ph_r == 2'h2)
            sub_r <= sub_r + 4'h1;
    end

    // Tick outputs
    assign o_tick_sixteen = (ph_r == 2'h2);
    assign o_tick_one     = (ph_r == 2'h2) && (sub_r == 4'hf);
endmodule // tcc_tick_gen

// ==== tcc_timer_sva.sv ====
// Port checker for the timer/counter
`timescale 1ns/1ps
module tcc_timer_sva
(
    // Clock, reset, ticks and tasks
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_periph_clk_sixteen_tick,
    input  wire logic        i_periph_clk_one_tick,
    input  wire logic        i_task_start,
    input  wire logic        i_task_halt,
    input  wire logic        i_task_increment,
    input  wire logic        i_task_zero,
    // Configuration
    input  wire logic        i_mode_counter,
    input  wire logic [1:0]  i_width_select,
    input  wire logic [3:0]  i_divider_exp,
    // Outputs watched
    input  wire logic        o_running,
    input  wire logic        o_slow_source,
    input  wire logic [31:0] o_count_value,
    input  wire logic [5:0]  o_match_event,
    input  wire logic [5:0]  o_match_flag
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic [31:0] msk;
    logic        idle;

    // Width mask and the absence of any counting cause
    assign msk  = i_width_select[0] ? (i_width_select[1] ? 32'hffffffff : 32'h000000ff)
                                    : (i_width_select[1] ? 32'h00ffffff : 32'h0000ffff);
    assign idle = i_mode_counter ? !i_task_increment
                                 : !(i_periph_clk_sixteen_tick || i_periph_clk_one_tick);

    a_halt_wins: assert property (i_task_halt |=> !o_running)
        else $error("halt did not stop the counter");
    a_start_runs: assert property (i_task_start && !i_task_halt |=> o_running)
        else $error("start did not run the counter");
    a_halt_holds: assert property (!o_running && !i_task_start && !i_task_zero |=> $stable(o_count_value))
        else $error("halted counter moved");
    a_inc_adds: assert property (i_mode_counter && o_running && i_task_increment && !i_task_zero
        && !i_task_halt |=> o_count_value == (($past(o_count_value) + 32'h1) & msk))
        else $error("increment did not add one within width");
    a_no_cause: assert property (idle && !i_task_zero |=> $stable(o_count_value))
        else $error("counter moved without its cause");
    a_zero_clr: assert property (i_task_zero |=> o_count_value == 32'h0)
        else $error("zero task did not clear");
    a_slow_pick: assert property ($past(i_rst_n) |-> o_slow_source == ($past(i_divider_exp) >= 4'h4))
        else $error("wrong tick source");
    a_event_flag: assert property ((o_match_event & ~o_match_flag) == 6'h0)
        else $error("match event without flag");
    a_event_moved: assert property (o_match_event != 6'h0 |-> o_count_value != $past(o_count_value))
        else $error("match event without increment");

    // Main scenarios
    c_match: cover property (o_match_event != 6'h0);
    c_both: cover property (i_task_start && i_task_halt);
    c_slow: cover property (o_slow_source && o_running);
endmodule // tcc_timer_sva

bind tcc_timer tcc_timer_sva SVA (.i_ref_clk, .i_rst_n, .i_periph_clk_sixteen_tick,
    .i_periph_clk_one_tick, .i_task_start, .i_task_halt, .i_task_increment, .i_task_zero,
    .i_mode_counter, .i_width_select, .i_divider_exp, .o_running, .o_slow_source,
    .o_count_value, .o_match_event, .o_match_flag);

// ==== tcc_timer_test.sv ====
// Self-checking bench for the timer/counter
`timescale 1ns/1ps
module tcc_timer_test;
    typedef struct {logic [1:0] w; logic [31:0] d; int c;} tcc_row_t;
    logic        clk, rst_n, t16, t1, st, hl, ic, zr, md, ru, sl;
    logic [1:0]  ws;
    logic [2:0]  rs;
    logic [3:0]  dx;
    logic [5:0]  sn, sm, we, fc, ev, fl;
    logic [31:0] wd, cv, rd;
    int          errors, cmp_count, x;
    logic [3:0]  ex [3] = '{4'h0, 4'h2, 4'h5};
    tcc_row_t    rows [4] = '{'{2'h1, 32'h55000003, 2}, '{2'h0, 32'hab000003, 3},
                              '{2'h2, 32'hff000003, 4}, '{2'h3, 32'h00000003, 5}};

    // Design and tick source
    tcc_timer DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_periph_clk_sixteen_tick(t16),
        .i_periph_clk_one_tick(t1), .i_task_start(st), .i_task_halt(hl), .i_task_increment(ic),
        .i_task_zero(zr), .i_task_snapshot(sn), .i_mode_counter(md), .i_width_select(ws),
        .i_divider_exp(dx), .i_single_match_enable(sm), .i_chan_wr_en(we), .i_chan_wr_data(wd),
        .i_chan_rd_sel(rs), .i_match_flag_clr(fc), .o_running(ru), .o_slow_source(sl),
        .o_count_value(cv), .o_chan_rd_data(rd), .o_match_event(ev), .o_match_flag(fl));
    tcc_tick_gen GEN (.i_ref_clk(clk), .i_rst_n(rst_n), .o_tick_sixteen(t16), .o_tick_one(t1));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task step;
        @(posedge clk);
        #1;
    endtask

    task chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // Task pulse {start, halt, increment, zero} with snapshots, then a quiet cycle
    task tk(input logic [3:0] t, input logic [5:0] s);
        {st, hl, ic, zr} = t;
        sn = s;
        step;
        {st, hl, ic, zr} = 4'h0;
        sn = 6'h0;
        step;
    endtask

    // Back-to-back increments
    task inc(input int n);
        ic = 1'b1;
        repeat (n) step;
        ic = 1'b0;
        step;
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        finish_test;
    end

    initial
    begin
        {rst_n, st, hl, ic, zr, md, ws, rs, dx, sn, sm, we, fc, wd} = '0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(ru === 1'b0 && cv === 32'h0 && fl === 6'h0, "reset state");
        foreach (rows[k])
        begin
            md = 1'b1;
            ws = rows[k].w;
            fc = 6'h3f;
            we = 6'h1 << rows[k].c;
            wd = rows[k].d;
            step;
            {fc, we} = 12'h0;
            tk(4'h9, 6'h0);
            inc(2);
            chk(fl[rows[k].c] === 1'b0, "early match");
            inc(1);
            chk(fl[rows[k].c] === 1'b1 && cv === 32'h3, "masked match");
            tk(4'h4, 6'h0);
        end
        $display("test rows done");
        ws = 2'h1;
        tk(4'h9, 6'h0);
        inc(256);
        chk(cv === 32'h0, "no wrap");
        inc(1);
        chk(cv === 32'h1, "no count after wrap");
        tk(4'h4, 6'h0);
        inc(2);
        chk(ru === 1'b0 && cv === 32'h1, "counted while halted");
        tk(4'h8, 6'h0);
        inc(1);
        chk(cv === 32'h2, "resume lost value");
        repeat (2)
        begin
            tk(4'hc, 6'h0);
            chk(ru === 1'b0, "start beat halt");
        end
        tk(4'h0, 6'h1);
        chk(rd === 32'h2, "snapshot value");
        tk(4'h1, 6'h1);
        chk(rd === 32'h0 && cv === 32'h0, "zero lost to snapshot");
        $display("test wrap halt snapshot done");
        sm = 6'h2;
        we = 6'h2;
        wd = 32'h1;
        step;
        we = 6'h0;
        tk(4'h9, 6'h0);
        ic = 1'b1;
        step;
        ic = 1'b0;
        chk(ev === 6'h2 && cv === 32'h1, "match event missing");
        step;
        chk(ev === 6'h0 && fl[1] === 1'b1, "first single match");
        fc = 6'h2;
        step;
        fc = 6'h0;
        chk(fl[1] === 1'b0, "flag not cleared");
        tk(4'h1, 6'h0);
        inc(1);
        chk(fl[1] === 1'b0, "second single match");
        $display("test single match done");
        tk(4'h4, 6'h0);
        md = 1'b0;
        ws = 2'h3;
        dx = 4'hf;
        tk(4'h9, 6'h0);
        inc(5);
        chk(cv === 32'h0 && sl === 1'b1, "timer took increment");
        foreach (ex[k])
        begin
            tk(4'h4, 6'h0);
            dx = ex[k];
            tk(4'h9, 6'h0);
            repeat (1534) step;
            tk(4'h4, 6'h0);
            x = 1536 / (3 << ex[k]);
            chk(cv >= x - 1 && cv <= x + 1, "tick rate");
            chk(sl === (ex[k] >= 4'h4), "tick source");
        end
        $display("test timer done");
        finish_test;
    end
endmodule // tcc_timer_test
